/* core/fbio_pkg.sv */
// Package for the four-pin I/O port shared with the LCD commons.
// Assumes a 32-bit AHB-Lite register bus and one 125 MHz system clock.
package fbio_pkg;

  // Port geometry
  localparam int PORT_W = 4;  // Number of port pins
  localparam int REG_W = 8;  // Width of each port register
  localparam int SEG_W = 4;  // Width of the segment select field
  localparam int MODE_W = 3;  // Width of the power mode field

  // Register indices; byte address is four times the index
  localparam logic [15:0] IDX_PORT_DATA = 16'hFFDD;  // Port data
  localparam logic [15:0] IDX_PORT_DIR = 16'hFFED;  // Port direction
  localparam logic [15:0] IDX_LCD_CTRL = 16'hFFC0;  // LCD port control
  localparam logic [15:0] IDX_PWR_MODE = 16'hFFC1;  // Power mode

  // Address decode fields
  localparam int ADDR_IDX_LSB = 2;  // Word index starts here
  localparam int ADDR_IDX_MSB = 17;  // Word index ends here

  // Reset values and fixed read values
  localparam logic [REG_W-1:0] PORT_DATA_RST = 8'hF0;  // Data register
  localparam logic [REG_W-1:0] PORT_DIR_RST = 8'hF0;  // Direction register
  localparam logic [SEG_W-1:0] SEG_GPIO = 4'h0;  // All pins are GPIO
  localparam logic [REG_W-1:0] READ_ALL_ONES = 8'hFF;  // Write-only read
  localparam logic [3:0] UPPER_ONES = 4'hF;  // Unused data bits

  // Power mode encodings held in the power mode register
  localparam logic [MODE_W-1:0] MODE_ACTIVE = 3'h0;  // Pins functional
  localparam logic [MODE_W-1:0] MODE_SUBACTIVE = 3'h1;  // Pins functional
  localparam logic [MODE_W-1:0] MODE_SLEEP = 3'h2;  // Pins hold
  localparam logic [MODE_W-1:0] MODE_SUBSLEEP = 3'h3;  // Pins hold
  localparam logic [MODE_W-1:0] MODE_WATCH = 3'h4;  // Pins hold
  localparam logic [MODE_W-1:0] MODE_STANDBY = 3'h5;  // Pins high-Z

  // AHB transfer type bit that marks an active transfer
  localparam int HTRANS_ACTIVE_BIT = 1;

  // Bus data phase states
  typedef enum logic [1:0] {
    BUS_IDLE,
    BUS_WRITE,
    BUS_READ
  } fbio_bus_state_type;

  // Captured address phase
  typedef struct packed {
    logic [31:0] haddr;
    logic hwrite;
  } fbio_req_type;

  // Pin drive pair seen at the pads
  typedef struct packed {
    logic [PORT_W-1:0] out;
    logic [PORT_W-1:0] oe_n;
  } fbio_pad_type;

endpackage : fbio_pkg

/* core/fbio_sync3.sv */
// Three-flop synchroniser with agreement filter, one lane per bit.
// Assumes the inputs come from pads outside the system clock domain.
`timescale 1ns/100ps
module fbio_sync3 #(
  parameter int WIDTH = 4
) (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);

  // One chain per bit
  genvar g;
  for (g = 0; g < WIDTH; g++) begin : g_lane
    logic s1_r;  // Metastable stage, read only by s2_r
    logic s2_r;  // Second stage
    logic s3_r;  // Third stage
    logic val_r;  // Accepted level

    // Shift chain
    always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
        s1_r <= 1'b0;
        s2_r <= 1'b0;
        s3_r <= 1'b0;
      end else begin
        s1_r <= i_async[g];
        s2_r <= s1_r;
        s3_r <= s2_r;
      end
    end

    // A change counts only once stages two and three agree
    always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
        val_r <= 1'b0;
      end else if (s2_r == s3_r) begin
        val_r <= s3_r;
      end
    end

    assign o_sync[g] = val_r;
  end

endmodule : fbio_sync3

/* core/fbio_port.sv */
// Four-pin I/O port with LCD common sharing, AHB-Lite register slave.
// Assumes one 125 MHz clock, pads resolved outside, LCD commons on clock.
//
// Contract
// - Data bits 3..0 hold pin data, upper read 1
// - Output pin reads return latched data bit
// - Input pin reads return sampled pin level
// - Direction 1 drives pin, 0 makes input
// - Data and direction apply only in GPIO
// - Data register resets to F0
// - Direction register resets to F0, all inputs
// - Direction register is write-only, reads all ones
// - Select zero is GPIO, else commons 4..1
// - Standby high-Z, sleeps hold, active modes run
// - Segment select lives in LCD port control
`timescale 1ns/100ps
module fbio_port (
  input wire logic i_clk,
  input wire logic i_nrst,
  // AHB-Lite slave
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic o_hreadyout,
  output logic o_hresp,
  output logic [31:0] o_hrdata,
  // LCD driver commons, ordered common 4 down to common 1
  input wire logic [fbio_pkg::PORT_W-1:0] i_lcd_common,
  // Pads
  input wire logic [fbio_pkg::PORT_W-1:0] i_pin_in,
  output logic [fbio_pkg::PORT_W-1:0] o_pin_out,
  output logic [fbio_pkg::PORT_W-1:0] o_pin_oe_n
);
  import fbio_pkg::*;

  // Register state
  logic [PORT_W-1:0] data_r;  // Pin output data
  logic [PORT_W-1:0] dir_r;  // Pin direction, 1 is output
  logic [SEG_W-1:0] seg_r;  // Segment select field
  logic [MODE_W-1:0] mode_r;  // Power mode

  // Bus state
  fbio_bus_state_type state_r;  // Data phase in progress
  fbio_req_type req_r;  // Captured address phase
  logic hready_r;  // Ready to the bus
  logic hresp_r;  // Always OKAY
  logic [31:0] hrdata_r;  // Read data

  // Pad state
  fbio_pad_type pad_r;  // Registered pad drive
  fbio_pad_type pad_nxt;  // Pad drive in functional modes

  // Misc nets
  logic [PORT_W-1:0] pin_sync;  // Filtered pin levels
  logic accept;  // Address phase taken this edge
  logic wr_fire;  // Write data phase ends this edge
  logic [15:0] req_idx;  // Word index of captured request
  logic addr_ok;  // Upper address bits are zero
  logic [REG_W-1:0] rd_val;  // Value for a read
  logic gpio_sel;  // Pins serve as GPIO

  // Pad input synchroniser
  // Pin levels reach the read path four edges after a pad change
  fbio_sync3 #(
    .WIDTH(PORT_W)
  ) u_sync (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_async(i_pin_in),
    .o_sync(pin_sync)
  );

  // Address phase is taken when selected, active and bus ready
  // Transfer size is not decoded; every register is one aligned word
  assign accept = i_hsel & i_htrans[HTRANS_ACTIVE_BIT] & i_hready;
  assign wr_fire = (state_r == BUS_WRITE) && req_r.hwrite;
  assign req_idx = req_r.haddr[ADDR_IDX_MSB:ADDR_IDX_LSB];
  assign addr_ok = (req_r.haddr[31:ADDR_IDX_MSB+1] == '0);

  // Bus state machine; reads take one wait state
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      state_r <= BUS_IDLE;
    end else begin
      case (state_r)
        BUS_IDLE, BUS_WRITE: begin
          // A write data phase may overlap the next address phase
          if (accept) begin
            state_r <= i_hwrite ? BUS_WRITE : BUS_READ;
          end else begin
            state_r <= BUS_IDLE;
          end
        end
        BUS_READ: begin
          // Read data is loaded now, bus goes ready
          state_r <= BUS_IDLE;
        end
        default: begin
          state_r <= BUS_IDLE;
        end
      endcase
    end
  end

  // Capture the address phase
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      req_r <= '0;
    end else if (accept) begin
      req_r.haddr <= i_haddr;
      req_r.hwrite <= i_hwrite;
    end
  end

  // Ready drops for one cycle after a read is taken
  // A write never stalls, so ready stays high for it
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      hready_r <= 1'b1;
      hresp_r <= 1'b0;
    end else begin
      hready_r <= !(accept && !i_hwrite);
      hresp_r <= 1'b0;
    end
  end

  // Read multiplexer
  always_comb begin
    rd_val = '0;
    if (addr_ok) begin
      case (req_idx)
        IDX_PORT_DATA: begin
          // Output pins echo latch, input pins show pad
          rd_val = {UPPER_ONES, (data_r & dir_r) | (pin_sync & ~dir_r)};
        end
        IDX_PORT_DIR: begin
          rd_val = READ_ALL_ONES;
        end
        IDX_LCD_CTRL: begin
          rd_val = {{(REG_W-SEG_W){1'b0}}, seg_r};
        end
        IDX_PWR_MODE: begin
          rd_val = {{(REG_W-MODE_W){1'b0}}, mode_r};
        end
        default: begin
          rd_val = '0;  // Unmapped reads zero
        end
      endcase
    end
  end

  // Read data is loaded in the wait state, after any prior write
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      hrdata_r <= '0;
    end else if (state_r == BUS_READ) begin
      hrdata_r <= {{(32-REG_W){1'b0}}, rd_val};
    end
  end

  // Port data register; upper bits are not stored
  // The upper nibble reads back as ones from the read path
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      data_r <= PORT_DATA_RST[PORT_W-1:0];
    end else if (wr_fire && addr_ok && req_idx == IDX_PORT_DATA) begin
      data_r <= i_hwdata[PORT_W-1:0];
    end
  end

  // Port direction register; upper bits are not stored
  // Only the low nibble is kept; a read never returns it
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      dir_r <= PORT_DIR_RST[PORT_W-1:0];
    end else if (wr_fire && addr_ok && req_idx == IDX_PORT_DIR) begin
      dir_r <= i_hwdata[PORT_W-1:0];
    end
  end

  // LCD port control, segment select field
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      seg_r <= SEG_GPIO;
    end else if (wr_fire && addr_ok && req_idx == IDX_LCD_CTRL) begin
      seg_r <= i_hwdata[SEG_W-1:0];
    end
  end

  // Power mode register
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      mode_r <= MODE_ACTIVE;
    end else if (wr_fire && addr_ok && req_idx == IDX_PWR_MODE) begin
      mode_r <= i_hwdata[MODE_W-1:0];
    end
  end

  // Pin function select
  assign gpio_sel = (seg_r == SEG_GPIO);

  // Per-pin drive in functional modes
  // LCD mode drives the pins even where direction says input
  genvar p;
  for (p = 0; p < PORT_W; p++) begin : g_pin
    always_comb begin
      if (gpio_sel) begin
        // GPIO: data and direction take effect
        pad_nxt.out[p] = data_r[p];
        pad_nxt.oe_n[p] = ~dir_r[p];
      end else begin
        // LCD common drives regardless of direction
        pad_nxt.out[p] = i_lcd_common[p];
        pad_nxt.oe_n[p] = 1'b0;
      end
    end
  end

  // Pad register follows the power mode
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      pad_r.out <= '0;
      pad_r.oe_n <= '1;
    end else begin
      case (mode_r)
        MODE_ACTIVE, MODE_SUBACTIVE: begin
          pad_r <= pad_nxt;
        end
        MODE_STANDBY: begin
          pad_r.oe_n <= '1;
        end
        default: begin
          // Sleep modes hold; undefined codes 6 and 7 hold as well
          pad_r <= pad_r;
        end
      endcase
    end
  end

  // Outputs straight from flops
  assign o_hreadyout = hready_r;
  assign o_hresp = hresp_r;
  assign o_hrdata = hrdata_r;
  assign o_pin_out = pad_r.out;
  assign o_pin_oe_n = pad_r.oe_n;

  // Checks
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_nrst);

  // Helper terms for the checks below
  logic rd_data_q;  // Read of data register completes
  logic rd_dir_q;  // Read of direction register completes
  logic run_mode;  // Pins functional
  logic hold_mode;  // Pins retain state
  assign rd_data_q = (state_r == BUS_READ) && addr_ok &&
                     (req_idx == IDX_PORT_DATA);
  assign rd_dir_q = (state_r == BUS_READ) && addr_ok &&
                    (req_idx == IDX_PORT_DIR);
  assign run_mode = (mode_r == MODE_ACTIVE) || (mode_r == MODE_SUBACTIVE);
  assign hold_mode = (mode_r == MODE_SLEEP) || (mode_r == MODE_SUBSLEEP) ||
                     (mode_r == MODE_WATCH);

  // Read checks look one edge after the wait state loads the data
  chk_data_upper_ones: assert property (
    rd_data_q |=> o_hrdata[REG_W-1:PORT_W] == UPPER_ONES && o_hreadyout)
    else $error("Port data upper bits not read as ones");

  chk_output_latched: assert property (
    rd_data_q |=> ((o_hrdata[PORT_W-1:0] ^ $past(data_r)) & $past(dir_r))
                  == '0)
    else $error("Output pin read did not return latched data");

  chk_input_sampled: assert property (
    rd_data_q |=> ((o_hrdata[PORT_W-1:0] ^ $past(pin_sync)) & ~$past(dir_r))
                  == '0)
    else $error("Input pin read did not return pin level");

  // Pad checks compare against register and LCD common input values one edge back
  chk_gpio_drive_dir: assert property (
    (run_mode && gpio_sel) |=> o_pin_oe_n == ~$past(dir_r) &&
                               o_pin_out == $past(data_r))
    else $error("GPIO pins do not follow data and direction");

  chk_lcd_common_out: assert property (
    (run_mode && !gpio_sel) |=> o_pin_oe_n == '0 &&
                                o_pin_out == $past(i_lcd_common))
    else $error("LCD commons not driven on pins");

  // Registers and pads leave reset at their reset levels
  chk_reset_regs: assert property (
    $rose(i_nrst) |-> data_r == PORT_DATA_RST[PORT_W-1:0] &&
                      dir_r == PORT_DIR_RST[PORT_W-1:0] &&
                      o_pin_oe_n == '1)
    else $error("Port registers not at reset value");

  chk_dir_write_only: assert property (
    rd_dir_q |=> o_hrdata[REG_W-1:0] == READ_ALL_ONES)
    else $error("Direction register read not all ones");

  chk_data_write: assert property (
    (wr_fire && addr_ok && req_idx == IDX_PORT_DATA)
      |=> data_r == $past(i_hwdata[PORT_W-1:0]))
    else $error("Port data write not stored");

  chk_dir_write: assert property (
    (wr_fire && addr_ok && req_idx == IDX_PORT_DIR)
      |=> dir_r == $past(i_hwdata[PORT_W-1:0]))
    else $error("Port direction write not stored");

  chk_seg_write: assert property (
    (wr_fire && addr_ok && req_idx == IDX_LCD_CTRL)
      |=> seg_r == $past(i_hwdata[SEG_W-1:0]))
    else $error("Segment select write not stored");

  chk_standby_hiz: assert property (
    (mode_r == MODE_STANDBY) |=> o_pin_oe_n == '1)
    else $error("Pins not high impedance in standby");

  // Standby only releases the pads; the output value is left as it was
  chk_standby_keep: assert property (
    (mode_r == MODE_STANDBY) |=> $stable(o_pin_out))
    else $error("Pin output value changed in standby");

  // Two hold cycles in a row, so the entry edge itself is excluded
  chk_sleep_hold: assert property (
    hold_mode [*2] |-> $stable(o_pin_out) && $stable(o_pin_oe_n))
    else $error("Pins changed in a holding mode");

  // Main scenarios that the bench should reach
  cov_read_data: cover property (rd_data_q ##1 o_hreadyout);
  cov_lcd_mode: cover property (run_mode && !gpio_sel ##1 o_pin_oe_n == '0);
  cov_standby: cover property (mode_r == MODE_STANDBY ##1 o_pin_oe_n == '1);
  cov_gpio_out: cover property (run_mode && gpio_sel && dir_r != '0);
  cov_hold_mode: cover property (hold_mode [*2]);

endmodule : fbio_port

/* dv/fbio_pads_model.sv */
// Board-side model of the four port pads and the LCD common lines.
// Assumes the port drives a pad while its enable is low.
`timescale 1ns/100ps
module fbio_pads_model (
  input wire logic i_clk,
  input wire logic [3:0] i_out,  // Port output value
  input wire logic [3:0] i_oe_n,  // Port drives while low
  input wire logic [3:0] i_ext,  // Board drive value
  input wire logic [3:0] i_ext_en,  // Board drives the pad
  input wire logic [3:0] i_force,  // Board overpowers the port
  input wire logic [3:0] i_com,  // Panel common pattern
  output logic [3:0] o_level,  // Resolved pad level
  output logic [3:0] o_com  // Commons into the port
);
  logic [3:0] float_r = 4'h5;  // Floating pad pattern

  // Undriven pads flip every cycle so a stale value never passes
  always @(posedge i_clk) begin
    float_r <= ~float_r;
  end

  // Resolve each pad from both parties
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      if (!i_oe_n[i] && !i_force[i]) begin
        o_level[i] = i_out[i];
      end else if (i_ext_en[i]) begin
        o_level[i] = i_ext[i];
      end else begin
        o_level[i] = float_r[i];
      end
    end
  end

  assign o_com = i_com;
endmodule : fbio_pads_model

/* dv/fbio_port_test.sv */
// Self-checking bench for the four-pin port over AHB-Lite.
// Assumes the pad model on the far side and one 8 ns clock.
`timescale 1ns/100ps
module fbio_port_test;
  import fbio_pkg::*;
  localparam logic [31:0] A_DATA = 32'h0003FF74;  // Data register
  localparam logic [31:0] A_DIR = 32'h0003FFB4;  // Direction register
  localparam logic [31:0] A_LCD = 32'h0003FF00;  // LCD port control
  localparam logic [31:0] A_MODE = 32'h0003FF04;  // Power mode
  logic i_clk = 1'b0;
  logic i_nrst = 1'b0;
  logic i_hsel = 1'b0;
  logic [31:0] i_haddr = 32'h0;
  logic [1:0] i_htrans = 2'h0;
  logic i_hwrite = 1'b0;
  logic [31:0] i_hwdata = 32'h0;
  logic o_hreadyout, o_hresp;
  logic [31:0] o_hrdata, rd;
  logic [3:0] lcd_com, pin_in, o_pin_out, o_pin_oe_n;
  logic [3:0] ext = 4'h5;  // Board level on the pads
  logic [3:0] ext_en = 4'hF;  // Board drives every pad
  logic [3:0] force_pin = 4'h0;  // Board overdrive
  logic [3:0] com = 4'h0;  // Panel common pattern
  logic [2:0] hold_m [3] = '{MODE_SLEEP, MODE_SUBSLEEP, MODE_WATCH};
  int checks = 0;
  int bad_count = 0;

  // Free-running clock
  initial begin
    forever #4 i_clk = ~i_clk;
  end

  fbio_port u_fbio_port (.i_clk(i_clk), .i_nrst(i_nrst),
    .i_hsel(i_hsel), .i_haddr(i_haddr), .i_htrans(i_htrans),
    .i_hwrite(i_hwrite), .i_hsize(3'h2), .i_hwdata(i_hwdata),
    .i_hready(o_hreadyout), .o_hreadyout(o_hreadyout),
    .o_hresp(o_hresp), .o_hrdata(o_hrdata), .i_lcd_common(lcd_com),
    .i_pin_in(pin_in), .o_pin_out(o_pin_out), .o_pin_oe_n(o_pin_oe_n));

  fbio_pads_model u_fbio_pads_model (.i_clk(i_clk), .i_out(o_pin_out),
    .i_oe_n(o_pin_oe_n), .i_ext(ext), .i_ext_en(ext_en),
    .i_force(force_pin), .i_com(com), .o_level(pin_in), .o_com(lcd_com));

  // Print counts and verdict, then stop
  task automatic conclude;
    $display("checks=%0d bad_count=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : conclude

  // Compare one value
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      bad_count++;
    end
  endtask : chk

  // Wait for hready sampled high, bounded
  task automatic wait_ready;
    int n;
    n = 0;
    do begin
      @(posedge i_clk);
      n++;
    end while (o_hreadyout !== 1'b1 && n < 16);
    if (o_hreadyout !== 1'b1) begin
      bad_count++;
      conclude;
    end
  endtask : wait_ready

  // One single word transfer, address phase then data phase
  task automatic bus(input logic [31:0] a, input logic w,
                     input logic [31:0] wd);
    i_hsel <= 1'b1;
    i_haddr <= a;
    i_hwrite <= w;
    i_htrans <= 2'h2;
    wait_ready;
    i_htrans <= 2'h0;
    i_hwdata <= wd;
    wait_ready;
    rd = o_hrdata;
    chk(o_hresp, 32'h0);
  endtask : bus

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    bus(a, 1'b1, d);
  endtask : wr

  task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
    bus(a, 1'b0, 32'h0);
    chk(rd, exp);
  endtask : rd_chk

  task automatic wait_n(input int n);
    repeat (n) @(posedge i_clk);
  endtask : wait_n

  // Hold reset for 8 cycles
  task automatic do_reset;
    i_nrst <= 1'b0;
    wait_n(8);
    i_nrst <= 1'b1;
    wait_n(1);
  endtask : do_reset

  // Hang guard
  initial begin
    wait_n(20000);
    bad_count++;
    conclude;
  end

  // Main sequence
  initial begin
    do_reset;
    chk(o_pin_oe_n, 4'hF);
    wait_n(5);
    rd_chk(A_DATA, 32'hF5);
    rd_chk(A_DIR, 32'hFF);
    wr(A_DIR, 32'hFF);
    rd_chk(A_DATA, 32'hF0);
    wr(A_DATA, 32'hAA);
    wr(A_DIR, 32'h0C);
    wait_n(3);
    chk(o_pin_oe_n, 4'h3);
    chk(o_pin_out[3:2], 2'h2);
    force_pin <= 4'hC;
    wait_n(6);
    rd_chk(A_DATA, 32'hF9);
    rd_chk(A_DIR, 32'hFF);
    force_pin <= 4'h0;
    // LCD commons take the pins for nonzero selects 1, 8 and 15
    for (int s = 1; s < 16; s += 7) begin
      com <= 4'(s) ^ 4'h6;
      wr(A_LCD, 32'(s));
      rd_chk(A_LCD, 32'(s));
      wait_n(3);
      chk(o_pin_oe_n, 4'h0);
      chk(o_pin_out, 4'(s) ^ 4'h6);
    end
    wr(A_DATA, 32'h5);
    wait_n(3);
    chk(o_pin_out, 4'h9);
    wr(A_LCD, 32'h0);
    wr(A_DATA, 32'h8);
    wait_n(3);
    chk(o_pin_oe_n, 4'h3);
    chk(o_pin_out[3:2], 2'h2);
    // Hold modes freeze the pads, active modes release them
    for (int k = 0; k < 3; k++) begin
      wr(A_MODE, {29'h0, hold_m[k]});
      rd_chk(A_MODE, {29'h0, hold_m[k]});
      wr(A_DATA, 32'h4);
      wait_n(3);
      chk(o_pin_out[3:2], 2'h2);
      wr(A_MODE, {29'h0, k[0] ? MODE_SUBACTIVE : MODE_ACTIVE});
      wait_n(3);
      chk(o_pin_out[3:2], 2'h1);
      wr(A_DATA, 32'h8);
    end
    wr(A_MODE, {29'h0, MODE_STANDBY});
    wait_n(3);
    chk(o_pin_oe_n, 4'hF);
    wr(A_MODE, {29'h0, MODE_ACTIVE});
    wait_n(3);
    chk(o_pin_oe_n, 4'h3);
    // Inputs follow a pad change
    ext <= 4'hA;
    wr(A_DIR, 32'h0);
    wait_n(6);
    chk(o_pin_oe_n, 4'hF);
    rd_chk(A_DATA, 32'hFA);
    // Unmapped places read zero
    wr(32'h0003FF08, 32'hFF);
    rd_chk(32'h0003FF08, 32'h0);
    rd_chk(32'h0007FF74, 32'h0);
    // Second reset in mid-run
    wr(A_DATA, 32'hF);
    do_reset;
    chk(o_pin_oe_n, 4'hF);
    wr(A_DIR, 32'h0F);
    rd_chk(A_DATA, 32'hF0);
    conclude;
  end
endmodule : fbio_port_test
